/* inc/atr_pkg.sv */
// Purpose: constants and types for the async timer register sync block
// Assumes: register indices are local choices, one byte per register
// Notes: timer clock is sampled from a pin by the main clock
package atr_pkg;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [2:0] ATR_ADDR_COUNT = 3'h0;
  localparam logic [2:0] ATR_ADDR_CMP = 3'h1;
  localparam logic [2:0] ATR_ADDR_CTRL = 3'h2;
  localparam logic [2:0] ATR_ADDR_STAT = 3'h3;
  localparam logic [2:0] ATR_ADDR_MASK = 3'h4;
  localparam logic [2:0] ATR_ADDR_FLAGS = 3'h5;
  localparam logic [2:0] ATR_ADDR_SYS = 3'h6;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int ATR_BIT_EXTCLK = 4;
  localparam int ATR_BIT_ASYNC = 3;
  localparam int ATR_BIT_CNT_UB = 2;
  localparam int ATR_BIT_CMP_UB = 1;
  localparam int ATR_BIT_CTL_UB = 0;
  localparam int ATR_BIT_CMP_IE = 1;
  localparam int ATR_BIT_OVF_IE = 0;
  localparam int ATR_BIT_CMP_F = 1;
  localparam int ATR_BIT_OVF_F = 0;
  localparam int ATR_BIT_GIE = 0;
  localparam int ATR_BIT_SLEEP = 1;
  localparam int ATR_BIT_DEEP = 2;
  localparam int ATR_BIT_ACK = 3;
  localparam logic [7:0] ATR_RST_BYTE = 8'h00;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int ATR_TEMP_EDGES = 2;
  localparam int ATR_WAKE_HOLD = 4;
  localparam int ATR_FLAG_SYNC = 3;
  typedef enum logic [1:0] {
    ATR_RUN = 2'b00,
    ATR_SLEEP = 2'b01,
    ATR_WAKE = 2'b10
  } atr_pwr_t;
  // one pending asynchronous write
  typedef struct packed {
    logic busy;
    logic [1:0] edges;
    logic [7:0] temp;
  } atr_pend_t;
  typedef struct packed {
    logic [2:0] pin_s;
    logic tclk_lvl;
    logic [7:0] count;
    logic [7:0] count_view;
    logic [7:0] cmp;
    logic [7:0] ctrl;
    atr_pend_t p_cnt;
    atr_pend_t p_cmp;
    atr_pend_t p_ctl;
    logic block_cmp;
    logic ext_en;
    logic async_sel;
    logic [1:0] mask;
    logic [1:0] flags;
    logic [1:0] raw_tog;
    logic [1:0] flag_dly0;
    logic [1:0] flag_dly1;
    logic gie;
    atr_pwr_t pwr;
    logic [2:0] hold;
    logic irq_armed;
    logic [7:0] rdata;
    logic cmp_out;
    logic osc_en;
    logic ext_buf_en;
    logic cmp_irq;
    logic ovf_irq;
    logic cpu_run;
  } atr_state_t;
endpackage : atr_pkg

/* core/atr_timer.sv */
// Purpose: 8-bit timer with async register crossing and busy flags
// Assumes: timer clock pin is sampled by mclk (mclk > 4x timer clock)
// Notes: waveform modes and prescaler are out of scope; ctrl is stored
//
// The plain strobed port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
module atr_timer
  import atr_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic timer_osc_in_pin,
  output logic [7:0] rdata,
  output logic compare_output_pin,
  output logic osc_enable,
  output logic ext_clock_buf_enable,
  output logic cmp_irq,
  output logic ovf_irq,
  output logic cpu_run
);
  atr_state_t s_r, s_nxt;
  logic tick;
  logic pin_rise;
  logic match;
  logic [7:0] cnt_inc;

  // ---------------------------------------------------------------
  // timer tick: pin edge when async, every cycle otherwise
  // ---------------------------------------------------------------
  // only second and third stages feed the edge detect
  assign pin_rise = s_r.pin_s[1] & s_r.pin_s[2] & ~s_r.tclk_lvl;
  assign tick = s_r.async_sel ? pin_rise : 1'b1;
  assign cnt_inc = s_r.count + 8'h01;
  // compare stays off while a count or compare write is pending
  assign match = (s_r.count == s_r.cmp) & ~s_r.block_cmp &
                 ~s_r.p_cnt.busy & ~s_r.p_cmp.busy;

  always_comb begin
    s_nxt = s_r;
    s_nxt.pin_s = {s_r.pin_s[1:0], timer_osc_in_pin};
    if (s_r.pin_s[1] == s_r.pin_s[2]) begin
      s_nxt.tclk_lvl = s_r.pin_s[2];
    end
    // -------------------------------------------------------------
    // timer domain work, one step per tick
    // -------------------------------------------------------------
    if (tick && s_r.pwr != ATR_WAKE) begin
      s_nxt.count = cnt_inc;
      s_nxt.block_cmp = 1'b0;
      if (match) begin
        s_nxt.raw_tog[ATR_BIT_CMP_F] = ~s_r.raw_tog[ATR_BIT_CMP_F];
        s_nxt.cmp_out = ~s_r.cmp_out;
      end
      if (s_r.count == 8'hff) begin
        s_nxt.raw_tog[ATR_BIT_OVF_F] = ~s_r.raw_tog[ATR_BIT_OVF_F];
      end
      s_nxt.count_view = s_r.count;
      s_nxt.irq_armed = 1'b1;
      // each pending write lands after two timer edges
      if (s_r.p_cnt.busy) begin
        s_nxt.p_cnt.edges = s_r.p_cnt.edges + 2'd1;
        if (s_r.p_cnt.edges == 2'(ATR_TEMP_EDGES - 1)) begin
          s_nxt.count = s_r.p_cnt.temp;
          s_nxt.count_view = s_r.p_cnt.temp;
          s_nxt.p_cnt.busy = 1'b0;
          s_nxt.block_cmp = 1'b1;
        end
      end
      if (s_r.p_cmp.busy) begin
        s_nxt.p_cmp.edges = s_r.p_cmp.edges + 2'd1;
        if (s_r.p_cmp.edges == 2'(ATR_TEMP_EDGES - 1)) begin
          s_nxt.cmp = s_r.p_cmp.temp;
          s_nxt.p_cmp.busy = 1'b0;
        end
      end
      if (s_r.p_ctl.busy) begin
        s_nxt.p_ctl.edges = s_r.p_ctl.edges + 2'd1;
        if (s_r.p_ctl.edges == 2'(ATR_TEMP_EDGES - 1)) begin
          s_nxt.ctrl = s_r.p_ctl.temp;
          s_nxt.p_ctl.busy = 1'b0;
        end
      end
    end
    // -------------------------------------------------------------
    // flag crossing: toggle seen, then a 2-cycle pipe
    // -------------------------------------------------------------
    s_nxt.flag_dly0 = s_r.raw_tog;
    s_nxt.flag_dly1 = s_r.flag_dly0;
    for (int i = 0; i < 2; i++) begin
      // set wins over clear
      if (s_r.flag_dly1[i] != s_r.flag_dly0[i]) begin
        s_nxt.flags[i] = 1'b1;
      end else if (wr && addr == ATR_ADDR_FLAGS && wdata[i]) begin
        s_nxt.flags[i] = 1'b0;
      end else if (wr && addr == ATR_ADDR_SYS && wdata[ATR_BIT_ACK] &&
                   (i == ATR_BIT_CMP_F ? s_r.cmp_irq : (s_r.ovf_irq &&
                   !s_r.cmp_irq))) begin
        s_nxt.flags[i] = 1'b0;
      end
    end
    // -------------------------------------------------------------
    // register writes
    // -------------------------------------------------------------
    if (wr) begin
      unique case (addr)
        ATR_ADDR_COUNT: begin
          if (s_r.async_sel) begin
            s_nxt.p_cnt = '{busy: 1'b1, edges: 2'd0, temp: wdata};
          end else begin
            s_nxt.count = wdata;
            s_nxt.count_view = wdata;
            s_nxt.block_cmp = 1'b1;
          end
        end
        ATR_ADDR_CMP: begin
          s_nxt.p_cmp.temp = wdata;
          if (s_r.async_sel) begin
            s_nxt.p_cmp.busy = 1'b1;
            s_nxt.p_cmp.edges = 2'd0;
          end else begin
            s_nxt.cmp = wdata;
          end
        end
        ATR_ADDR_CTRL: begin
          s_nxt.p_ctl.temp = wdata;
          if (s_r.async_sel) begin
            s_nxt.p_ctl.busy = 1'b1;
            s_nxt.p_ctl.edges = 2'd0;
          end else begin
            s_nxt.ctrl = wdata;
          end
        end
        ATR_ADDR_STAT: begin
          s_nxt.ext_en = wdata[ATR_BIT_EXTCLK];
          s_nxt.async_sel = wdata[ATR_BIT_ASYNC];
        end
        ATR_ADDR_MASK: begin
          s_nxt.mask = wdata[1:0];
        end
        ATR_ADDR_SYS: begin
          s_nxt.gie = wdata[ATR_BIT_GIE];
          if (wdata[ATR_BIT_SLEEP] && s_r.pwr == ATR_RUN) begin
            s_nxt.pwr = ATR_SLEEP;
          end
          if (wdata[ATR_BIT_DEEP]) begin
            // contents are undefined after deep sleep; cleared here
            s_nxt.count = ATR_RST_BYTE;
            s_nxt.cmp = ATR_RST_BYTE;
            s_nxt.ctrl = ATR_RST_BYTE;
            s_nxt.p_cnt = '0;
            s_nxt.p_cmp = '0;
            s_nxt.p_ctl = '0;
          end
        end
        default: begin
        end
      endcase
    end
    // -------------------------------------------------------------
    // sleep and wake
    // -------------------------------------------------------------
    unique case (s_r.pwr)
      ATR_RUN: begin
      end
      ATR_SLEEP: begin
        // a re-entry before one timer cycle delays the wake: the first tick only re-arms irq_armed
        if (s_r.irq_armed && (s_r.cmp_irq || s_r.ovf_irq) && tick) begin
          s_nxt.pwr = ATR_WAKE;
          s_nxt.hold = 3'd0;
        end
      end
      ATR_WAKE: begin
        s_nxt.hold = s_r.hold + 3'd1;
        if (s_r.hold == 3'(ATR_WAKE_HOLD - 1)) begin
          s_nxt.pwr = ATR_RUN;
          s_nxt.irq_armed = 1'b0;
        end
      end
      default: begin
        s_nxt.pwr = ATR_RUN;
      end
    endcase
    // -------------------------------------------------------------
    // outputs
    // -------------------------------------------------------------
    s_nxt.rdata = 8'h00;
    if (rd) begin
      unique case (addr)
        ATR_ADDR_COUNT: s_nxt.rdata = s_r.async_sel ? s_r.count_view
                                                    : s_r.count;
        ATR_ADDR_CMP: s_nxt.rdata = s_r.p_cmp.temp;
        ATR_ADDR_CTRL: s_nxt.rdata = s_r.p_ctl.temp;
        ATR_ADDR_STAT: s_nxt.rdata = {3'h0, s_r.ext_en, s_r.async_sel,
          s_r.p_cnt.busy, s_r.p_cmp.busy, s_r.p_ctl.busy};
        ATR_ADDR_MASK: s_nxt.rdata = {6'h00, s_r.mask};
        ATR_ADDR_FLAGS: s_nxt.rdata = {6'h00, s_r.flags};
        ATR_ADDR_SYS: s_nxt.rdata = {7'h00, s_r.gie};
        default: s_nxt.rdata = 8'h00;
      endcase
    end
    s_nxt.osc_en = s_r.async_sel & ~s_r.ext_en;
    s_nxt.ext_buf_en = s_r.async_sel & s_r.ext_en;
    s_nxt.cmp_irq = s_r.gie & s_r.mask[ATR_BIT_CMP_IE] &
                    s_r.flags[ATR_BIT_CMP_F];
    s_nxt.ovf_irq = s_r.gie & s_r.mask[ATR_BIT_OVF_IE] &
                    s_r.flags[ATR_BIT_OVF_F];
    s_nxt.cpu_run = (s_nxt.pwr == ATR_RUN);
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s_r <= '0;
      s_r.cpu_run <= 1'b1;
    end else if (clk_en) begin
      s_r <= s_nxt;
    end
  end

  assign rdata = s_r.rdata;
  assign compare_output_pin = s_r.cmp_out;
  assign osc_enable = s_r.osc_en;
  assign ext_clock_buf_enable = s_r.ext_buf_en;
  assign cmp_irq = s_r.cmp_irq;
  assign ovf_irq = s_r.ovf_irq;
  assign cpu_run = s_r.cpu_run;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  busy_on_write_a: assert property (
    clk_en && wr && addr == ATR_ADDR_CMP && s_r.async_sel
    |=> s_r.p_cmp.busy)
    else $error("cmp busy not set");
  cnt_busy_a: assert property (
    clk_en && wr && addr == ATR_ADDR_COUNT && s_r.async_sel
    |=> s_r.p_cnt.busy)
    else $error("count busy not set");
  ctl_busy_a: assert property (
    clk_en && wr && addr == ATR_ADDR_CTRL && s_r.async_sel
    |=> s_r.p_ctl.busy)
    else $error("ctrl busy not set");
  busy_hold_a: assert property (
    clk_en && s_r.p_cmp.busy && !tick && !wr
    |=> s_r.p_cmp.busy)
    else $error("cmp busy dropped early");
  cnt_load_a: assert property (
    clk_en && tick && s_r.pwr != ATR_WAKE && !wr && s_r.p_cnt.busy &&
    s_r.p_cnt.edges == 2'd1
    |=> !s_r.p_cnt.busy && s_r.count == $past(s_r.p_cnt.temp))
    else $error("count not loaded");
  cmp_load_a: assert property (
    clk_en && tick && s_r.pwr != ATR_WAKE && !wr && s_r.p_cmp.busy &&
    s_r.p_cmp.edges == 2'd1
    |=> !s_r.p_cmp.busy && s_r.cmp == $past(s_r.p_cmp.temp))
    else $error("compare not loaded");
  ctl_load_a: assert property (
    clk_en && tick && s_r.pwr != ATR_WAKE && !wr && s_r.p_ctl.busy &&
    s_r.p_ctl.edges == 2'd1
    |=> !s_r.p_ctl.busy && s_r.ctrl == $past(s_r.p_ctl.temp))
    else $error("ctrl not loaded");
  sep_temp_a: assert property (
    clk_en && wr && addr == ATR_ADDR_CMP && s_r.p_cnt.busy && !tick
    |=> s_r.p_cnt.busy && s_r.p_cnt.temp == $past(s_r.p_cnt.temp))
    else $error("count temp disturbed");
  cnt_sync_write_a: assert property (
    clk_en && wr && addr == ATR_ADDR_COUNT && !s_r.async_sel
    |=> s_r.count == $past(wdata))
    else $error("count write lost");
  block_cmp_a: assert property (
    clk_en && wr && addr == ATR_ADDR_COUNT && !s_r.async_sel
    |=> s_r.block_cmp)
    else $error("match not blocked");
  cmp_read_temp_a: assert property (
    clk_en && rd && addr == ATR_ADDR_CMP
    |=> rdata == $past(s_r.p_cmp.temp))
    else $error("cmp read wrong");
  cnt_read_a: assert property (
    clk_en && rd && addr == ATR_ADDR_COUNT && !s_r.async_sel
    |=> rdata == $past(s_r.count))
    else $error("count read wrong");
  rdata_idle_a: assert property (
    clk_en && !rd
    |=> rdata == 8'h00)
    else $error("read data not idle");

  // ---------------------------------------------------------------
  // checks: timer domain
  // ---------------------------------------------------------------
  no_match_pend_a: assert property (
    s_r.p_cmp.busy |-> !match)
    else $error("match during pending");
  sync_tick_a: assert property (
    clk_en && !s_r.async_sel && s_r.pwr != ATR_WAKE && !wr &&
    !s_r.p_cnt.busy
    |=> s_r.count == $past(s_r.count) + 8'h01)
    else $error("sync count stalled");
  async_hold_a: assert property (
    clk_en && s_r.async_sel && !pin_rise && !wr
    |=> s_r.count == $past(s_r.count))
    else $error("async count moved");
  view_follow_a: assert property (
    clk_en && tick && s_r.pwr != ATR_WAKE && !wr && !s_r.p_cnt.busy
    |=> s_r.count_view == $past(s_r.count))
    else $error("count view not refreshed");
  view_still_a: assert property (
    clk_en && !tick && !wr
    |=> $stable(s_r.count_view))
    else $error("count view moved");
  pin_toggle_a: assert property (
    clk_en && tick && s_r.pwr != ATR_WAKE && match
    |=> compare_output_pin != $past(compare_output_pin))
    else $error("compare pin not toggled");
  pin_still_a: assert property (
    clk_en && !match
    |=> $stable(compare_output_pin))
    else $error("compare pin moved");

  // ---------------------------------------------------------------
  // checks: interrupts, clock source and power
  // ---------------------------------------------------------------
  cmp_flag_set_a: assert property (
    clk_en && s_r.flag_dly1[1] != s_r.flag_dly0[1]
    |=> s_r.flags[1])
    else $error("compare flag not set");
  ovf_flag_set_a: assert property (
    clk_en && s_r.flag_dly1[0] != s_r.flag_dly0[0]
    |=> s_r.flags[0])
    else $error("overflow flag not set");
  cmp_irq_a: assert property (
    clk_en && s_r.gie && s_r.mask[1] && s_r.flags[1]
    |=> cmp_irq)
    else $error("cmp irq missing");
  cmp_irq_off_a: assert property (
    clk_en && !s_r.mask[1]
    |=> !cmp_irq)
    else $error("cmp irq while masked");
  ovf_irq_a: assert property (
    clk_en && !s_r.gie
    |=> !ovf_irq)
    else $error("ovf irq w/o gie");
  ovf_irq_on_a: assert property (
    clk_en && s_r.gie && s_r.mask[0] && s_r.flags[0]
    |=> ovf_irq)
    else $error("ovf irq missing");
  flag_clear_a: assert property (
    clk_en && wr && addr == ATR_ADDR_FLAGS && wdata[1] &&
    s_r.flag_dly1[1] == s_r.flag_dly0[1]
    |=> !s_r.flags[1])
    else $error("flag not cleared");
  osc_sel_a: assert property (
    clk_en && s_r.async_sel && s_r.ext_en
    |=> ext_clock_buf_enable && !osc_enable)
    else $error("osc sel");
  osc_run_a: assert property (
    clk_en && s_r.async_sel && !s_r.ext_en
    |=> osc_enable && !ext_clock_buf_enable)
    else $error("crystal not running");
  osc_off_a: assert property (
    clk_en && !s_r.async_sel
    |=> !osc_enable && !ext_clock_buf_enable)
    else $error("timer source on in sync mode");
  wake_hold_a: assert property (
    clk_en && s_r.pwr == ATR_SLEEP && s_nxt.pwr == ATR_WAKE
    |=> !cpu_run ##1 !cpu_run)
    else $error("wake hold short");
  wake_end_a: assert property (
    clk_en && s_r.pwr == ATR_WAKE && s_r.hold == 3'(ATR_WAKE_HOLD - 1)
    |=> cpu_run)
    else $error("wake hold long");
  disarm_a: assert property (
    clk_en && s_r.pwr == ATR_WAKE && s_r.hold == 3'(ATR_WAKE_HOLD - 1)
    |=> !s_r.irq_armed)
    else $error("irq logic not reset");
  deep_clear_a: assert property (
    clk_en && wr && addr == ATR_ADDR_SYS && wdata[ATR_BIT_DEEP]
    |=> s_r.count == 8'h00 && s_r.p_cmp.temp == 8'h00 && !s_r.p_cnt.busy)
    else $error("deep sleep kept contents");

  // main scenarios seen
  cov_async_c: cover property (s_r.p_cnt.busy ##[1:200] !s_r.p_cnt.busy);
  cov_cmp_c: cover property (cmp_irq);
  cov_wake_c: cover property (s_r.pwr == ATR_WAKE);
  cov_ovf_c: cover property (ovf_irq);
  cov_load_c: cover property (s_r.p_cmp.busy ##1 !s_r.p_cmp.busy);
endmodule : atr_timer
`default_nettype wire

/* sim/atr_osc_model.sv */
// Purpose: timer crystal or external clock feeding the timer pin
// Assumes: 400 ns period, eight main clock cycles per timer cycle
// Notes: pin rests low while the source is gated off, no free running
`timescale 1ns/1ps
`default_nettype none
module atr_osc_model #(
  parameter int HALF_NS = 200
) (
  input wire logic run,
  output logic pin
);
  initial begin
    pin = 1'b0;
    forever begin
      if (run) begin
        #HALF_NS pin = ~pin;
      end else begin
        pin = 1'b0;
        #50;
      end
    end
  end
endmodule : atr_osc_model
`default_nettype wire

/* sim/tb_async_timer_register_sync.sv */
// Purpose: register level bench for the async timer block
// Assumes: timer source gated by bench and by the block's own enables
// Notes: async count reads are checked in windows since the timer keeps running
`timescale 1ns/1ps
`default_nettype none
module tb_async_timer_register_sync;
  import atr_pkg::*;
  logic mclk, rstn, clk_en, wr, rd, pin, run_q;
  logic [2:0] addr;
  logic [7:0] wdata, rdata, v, v2;
  logic cmp_pin, osc_en, ext_en, cmp_irq, ovf_irq, cpu_run;
  wire logic osc_go;
  int error_cnt, num_checks;

  assign osc_go = run_q & (osc_en | ext_en);

  atr_timer atr_timer_inst(.mclk(mclk), .rstn(rstn), .clk_en(clk_en),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .timer_osc_in_pin(pin),
    .rdata(rdata), .compare_output_pin(cmp_pin), .osc_enable(osc_en),
    .ext_clock_buf_enable(ext_en), .cmp_irq(cmp_irq), .ovf_irq(ovf_irq),
    .cpu_run(cpu_run));
  atr_osc_model atr_osc_model_inst(.run(osc_go), .pin(pin));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // ---------------------------------------------------------------
  // bus tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd_reg
  task automatic expect_reg(input logic [2:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd_reg(a, d);
    check(d, e);
  endtask : expect_reg
  task automatic end_of_test;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_of_test
  task automatic timeout_hit;
    error_cnt++;
    $display("[FAIL] t=%0t wait ran out", $time);
    end_of_test();
  endtask : timeout_hit
  function automatic logic sel(input int w);
    case (w)
      0: return cmp_pin;
      1: return cmp_irq;
      2: return ovf_irq;
      default: return cpu_run;
    endcase
  endfunction : sel
  // bounded wait on one of the block's outputs
  task automatic wait_sig(input int w, input logic lvl, input int bound);
    int i;
    for (i = 0; i < bound && sel(w) !== lvl; i++) begin
      @(posedge mclk);
      #1;
    end
    if (i == bound) timeout_hit();
  endtask : wait_sig
  task automatic wait_idle;
    int i;
    logic [7:0] d;
    d = 8'hff;
    for (i = 0; i < 100 && d[2:0] !== 3'h0; i++) rd_reg(ATR_ADDR_STAT, d);
    if (i == 100) timeout_hit();
  endtask : wait_idle

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    rstn = 1'b0;
    clk_en = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 3'h0;
    wdata = 8'h00;
    run_q = 1'b0;
    error_cnt = 0;
    num_checks = 0;
    repeat (4) @(posedge mclk);
    rstn <= 1'b1;
    expect_reg(ATR_ADDR_STAT, 8'h00);
    check({6'h0, cpu_run, osc_en}, 8'h02);
    expect_reg(3'h7, 8'h00);
    // sync mode: the count follows the main clock
    wr_reg(ATR_ADDR_COUNT, 8'h10);
    rd_reg(ATR_ADDR_COUNT, v);
    rd_reg(ATR_ADDR_COUNT, v2);
    check(v2 - v, 8'h02);
    // clock enable low freezes the count for three edges
    @(posedge mclk);
    clk_en <= 1'b0;
    repeat (3) @(posedge mclk);
    clk_en <= 1'b1;
    rd_reg(ATR_ADDR_COUNT, v2);
    check(v2 - v, 8'h05);
    expect_reg(ATR_ADDR_STAT, 8'h00);
    // external clock enabled first, then async select
    wr_reg(ATR_ADDR_STAT, 8'h10);
    wr_reg(ATR_ADDR_STAT, 8'h18);
    @(posedge mclk);
    #1;
    check({6'h0, ext_en, osc_en}, 8'h02);
    expect_reg(ATR_ADDR_STAT, 8'h18);
    // timer source held still so the writes stay pending
    wr_reg(ATR_ADDR_COUNT, 8'h40);
    expect_reg(ATR_ADDR_STAT, 8'h1c);
    wr_reg(ATR_ADDR_CMP, 8'h50);
    wr_reg(ATR_ADDR_CTRL, 8'h07);
    expect_reg(ATR_ADDR_STAT, 8'h1f);
    expect_reg(ATR_ADDR_CMP, 8'h50);
    expect_reg(ATR_ADDR_CTRL, 8'h07);
    run_q <= 1'b1;
    wait_idle();
    rd_reg(ATR_ADDR_COUNT, v);
    check({7'h0, v >= 8'h40 && v <= 8'h44}, 8'h01);
    // compare match: pin toggle, flag and interrupt
    // the match at count zero after reset left a flag; clear it first
    wr_reg(ATR_ADDR_FLAGS, 8'h03);
    wr_reg(ATR_ADDR_MASK, 8'h02);
    wr_reg(ATR_ADDR_SYS, 8'h01);
    wait_sig(0, ~cmp_pin, 3000);
    rd_reg(ATR_ADDR_COUNT, v);
    check({7'h0, v >= 8'h50 && v <= 8'h53}, 8'h01);
    wait_sig(1, 1'b1, 20);
    rd_reg(ATR_ADDR_FLAGS, v);
    check(v & 8'h02, 8'h02);
    wr_reg(ATR_ADDR_FLAGS, 8'h02);
    @(posedge mclk);
    #1;
    check({7'h0, cmp_irq}, 8'h00);
    // overflow interrupt, then masked
    wr_reg(ATR_ADDR_MASK, 8'h01);
    wait_sig(2, 1'b1, 4000);
    wr_reg(ATR_ADDR_MASK, 8'h00);
    @(posedge mclk);
    #1;
    check({7'h0, ovf_irq}, 8'h00);
    wr_reg(ATR_ADDR_FLAGS, 8'h01);
    // timer sleep, woken by the next compare match
    wr_reg(ATR_ADDR_MASK, 8'h02);
    wr_reg(ATR_ADDR_SYS, 8'h03);
    @(posedge mclk);
    #1;
    check({7'h0, cpu_run}, 8'h00);
    wait_sig(3, 1'b1, 4000);
    rd_reg(ATR_ADDR_FLAGS, v);
    check(v & 8'h02, 8'h02);
    wr_reg(ATR_ADDR_SYS, 8'h09);
    rd_reg(ATR_ADDR_FLAGS, v);
    check(v & 8'h02, 8'h00);
    // deepest sleep loses the timer registers
    wr_reg(ATR_ADDR_SYS, 8'h04);
    expect_reg(ATR_ADDR_CMP, 8'h00);
    expect_reg(ATR_ADDR_CTRL, 8'h00);
    end_of_test();
  end
endmodule : tb_async_timer_register_sync
`default_nettype wire
